// ---- core/remote_io_pkg.sv ----
/*
  Shared constants and types of the remote base update and mismatch block.
  Assumes a single 125 MHz clock and an APB register port of 32 bits.
*/
`default_nettype none
package remote_io_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 1000000;           // One millisecond
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SYNC_SETTLE = 3;                    // Cycles before strap read
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CFG      = 8'h04;
  localparam logic [7:0] OFS_EXPECT0  = 8'h10;       // Four words of types
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_MISMATCH = 8'h24;
  localparam logic [7:0] OFS_DIAG0    = 8'h30;       // Four words of diag
  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_INT_LSB = 0;
  localparam int CTRL_FAC_LSB = 8;
  localparam int CTRL_TOL_BIT = 16;
  localparam logic [7:0] INTERVAL_RST = 8'h01;
  localparam logic [7:0] FACTOR_RST = 8'h02;
  localparam logic [7:0] EMPTY_TYPE = 8'h00;         // Unconfigured slot
  // ----------------------------------------------------------------
  // Status digits and diagnostic constants
  // ----------------------------------------------------------------
  localparam logic [3:0] DIGIT_READY = 4'h0;
  localparam logic [3:0] DIGIT_MISMATCH = 4'h2;
  localparam logic [3:0] DIGIT_NO_LINK = 4'h3;
  localparam logic [3:0] DIGIT_NO_CFG = 4'h7;
  localparam int DIAG_BYTES = 15;
  localparam logic [7:0] DIAG_DEV_HDR = 8'h06;
  localparam logic [7:0] DIAG_ID_HDR = 8'h43;
  localparam logic [7:0] DIAG_NO_MASTER = 8'hFF;
  localparam logic [7:0] DIAG_ST2_FIXED = 8'h04;     // Bit 2 always one
  localparam int ST1_EXT_BIT = 3;
  localparam int ST1_CFG_ERR_BIT = 2;
  localparam int ST1_NOT_READY_BIT = 1;

  // Update settings carried together
  typedef struct packed {
    logic       tolerance;
    logic [7:0] factor;
    logic [7:0] interval;
  } ctrl_t;

  // Link-loss output actions
  typedef struct packed {
    logic disc_clear;
    logic disc_hold;
  } loss_act_t;
endpackage
`default_nettype wire

// ---- core/remote_base_ctrl.sv ----
/*
  Update scheduling, link-loss output control and base mismatch handling
  of a fieldbus remote base controller, with an APB register slave.
  Assumes the link state, the strap jumper and the installed module types
  arrive from outside the clock domain; the APB master shares MCLK.
*/
// The APB slave port and the placing of the registers are this design's own decisions.
// Functional notes
// - On link loss discrete outputs follow only the output-loss jumper.
// - A missing jumper acts as the off setting.
// - Jumper off: word output zeroes only if module selects zero.
// - Jumper freeze: every word output keeps its last value.
// - Module hold selection overrides the off jumper for word outputs.
// - Discrete updates at most once per interval of 1-255 ms, default 1.
// - Word updates once every N discrete updates, N 1-255, default 2.
// - Tolerance off: no updates unless configuration matches exactly.
// - Tolerance on: update matching modules, skip mismatched ones.
// - Expected and installed modules compared continuously, differences flagged.
// - Tolerance off, removed or wrong module: status 2, outputs per jumper.
// - Tolerance off, module in unconfigured slot ignored, status 0.
// - Tolerance on, removed or wrong module: status 2 with point.
// - Tolerance on, unconfigured slot module ignored, status 0 with point.
// - Diagnostic has standard bytes 1-6 and extended bytes 7-15.
// - Bit 7 is MSB and bit 0 LSB in each diagnostic byte.
// - Bytes 5 and 6 carry a fixed two-byte identification code.
// - Tolerance enabled lights the decimal point with any digit.
// - Tolerance off, wrong module takes the whole base offline.
// - Jumper sampled only at startup; changes need a reset.
`timescale 1ns/1ps
`default_nettype none
module remote_base_ctrl #(
  parameter int NSLOT = 16,
  parameter int TYPE_W = 8,
  parameter int TICK_DIV = remote_io_pkg::TICK_CYCLES,
  parameter logic [7:0] IDENT_HI = 8'h5A,            // Arbitrary value
  parameter logic [7:0] IDENT_LO = 8'h3C             // Arbitrary value
) (
  input  wire logic                    MCLK,
  input  wire logic                    RESET,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [7:0]              PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic [31:0]                  PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  input  wire logic                    LINK_UP,
  input  wire logic                    JUMPER_FITTED,
  input  wire logic                    JUMPER_FREEZE,
  input  wire logic [NSLOT*TYPE_W-1:0] INSTALLED_TYPE,
  input  wire logic [NSLOT-1:0]        MODULE_ZERO_SEL,
  output logic                         DISC_UPDATE,
  output logic                         WORD_UPDATE,
  output logic [NSLOT-1:0]             SLOT_UPDATE_EN,
  output logic                         DISC_CLEAR,
  output logic                         DISC_HOLD,
  output logic [NSLOT-1:0]             WORD_ZERO,
  output logic [NSLOT-1:0]             WORD_HOLD,
  output logic                         BASE_OFFLINE,
  output logic [3:0]                   STATUS_DIGIT,
  output logic                         STATUS_POINT
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [NSLOT*TYPE_W+2:0] meta_r;
  logic [NSLOT*TYPE_W+2:0] sync_r;
  logic [NSLOT-1:0]        zsel_meta_r;
  logic [NSLOT-1:0]        zsel_r;
  logic                    link_s;
  logic                    fit_s;
  logic                    frz_s;

  // Two flops on the link, jumper, type and zero-select inputs
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      meta_r      <= '0;
      sync_r      <= '0;
      zsel_meta_r <= '0;
      zsel_r      <= '0;
    end
    else
    begin
      meta_r      <= {LINK_UP, JUMPER_FITTED, JUMPER_FREEZE, INSTALLED_TYPE};
      sync_r      <= meta_r;
      zsel_meta_r <= MODULE_ZERO_SEL;
      zsel_r      <= zsel_meta_r;
    end
  end
  assign link_s = sync_r[NSLOT*TYPE_W+2];
  assign fit_s  = sync_r[NSLOT*TYPE_W+1];
  assign frz_s  = sync_r[NSLOT*TYPE_W];

  // ----------------------------------------------------------------
  // Startup strap capture
  // ----------------------------------------------------------------
  logic [1:0] settle_r;
  logic [1:0] settle_nxt;
  logic       strap_done_r;
  logic       strap_done_nxt;
  logic       freeze_r;
  logic       freeze_nxt;

  // Jumper read once after synchronisers settle
  always_comb
  begin
    settle_nxt     = settle_r;
    strap_done_nxt = strap_done_r;
    freeze_nxt     = freeze_r;
    if (!strap_done_r)
    begin
      settle_nxt = settle_r + 2'h1;
      if (settle_r == 2'(remote_io_pkg::SYNC_SETTLE - 1))
      begin
        strap_done_nxt = 1'b1;
        freeze_nxt     = fit_s & frz_s;
      end
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      settle_r     <= 2'h0;
      strap_done_r <= 1'b0;
      freeze_r     <= 1'b0;
    end
    else
    begin
      settle_r     <= settle_nxt;
      strap_done_r <= strap_done_nxt;
      freeze_r     <= freeze_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  remote_io_pkg::ctrl_t       ctrl_r;
  remote_io_pkg::ctrl_t       ctrl_nxt;
  logic                       cfg_valid_r;
  logic                       cfg_valid_nxt;
  logic [NSLOT*TYPE_W-1:0]    expect_r;
  logic [NSLOT*TYPE_W-1:0]    expect_nxt;
  logic [31:0]                rdata_r;
  logic [31:0]                rdata_nxt;
  logic                       err_r;
  logic                       err_nxt;
  logic [NSLOT-1:0]           mism;
  logic [7:0]                 diag [16];
  logic                       setup;
  logic                       wr_en;

  assign setup = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & PWRITE;

  // Decode and capture read data in the setup cycle, write in the access cycle
  always_comb
  begin
    ctrl_nxt      = ctrl_r;
    cfg_valid_nxt = cfg_valid_r;
    expect_nxt    = expect_r;
    rdata_nxt     = rdata_r;
    err_nxt       = err_r;
    if (setup)
    begin
      rdata_nxt = 32'h0000_0000;
      err_nxt   = 1'b0;
      case (PADDR)
        remote_io_pkg::OFS_CTRL:
          rdata_nxt = {15'h0000, ctrl_r};
        remote_io_pkg::OFS_CFG:
          rdata_nxt = {31'h0000_0000, cfg_valid_r};
        remote_io_pkg::OFS_STATUS:
          rdata_nxt = {24'h00_0000, BASE_OFFLINE, link_s, freeze_r,
                       STATUS_POINT, STATUS_DIGIT};
        remote_io_pkg::OFS_MISMATCH:
          rdata_nxt = {16'(mism), 16'(mism)};
        default:
        begin
          if (PADDR[7:4] == remote_io_pkg::OFS_EXPECT0[7:4]
              && int'(PADDR[3:2]) < NSLOT / 4)
            rdata_nxt = expect_r[PADDR[3:2]*32 +: 32];
          else if (PADDR[7:4] == remote_io_pkg::OFS_DIAG0[7:4])
            rdata_nxt = {diag[{PADDR[3:2], 2'h3}], diag[{PADDR[3:2], 2'h2}],
                         diag[{PADDR[3:2], 2'h1}], diag[{PADDR[3:2], 2'h0}]};
          else
            err_nxt = 1'b1;                // Unmapped address
        end
      endcase
    end
    if (wr_en && !err_r)
    begin
      if (PADDR == remote_io_pkg::OFS_CTRL)
        ctrl_nxt = PWDATA[remote_io_pkg::CTRL_TOL_BIT:0];
      else if (PADDR == remote_io_pkg::OFS_CFG)
        cfg_valid_nxt = PWDATA[0];
      else if (PADDR[7:4] == remote_io_pkg::OFS_EXPECT0[7:4])
        expect_nxt[PADDR[3:2]*32 +: 32] = PWDATA;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      ctrl_r      <= '{tolerance: 1'b0, factor: remote_io_pkg::FACTOR_RST,
                       interval: remote_io_pkg::INTERVAL_RST};
      cfg_valid_r <= 1'b0;
      expect_r    <= '0;
      rdata_r     <= 32'h0000_0000;
      err_r       <= 1'b0;
    end
    else
    begin
      ctrl_r      <= ctrl_nxt;
      cfg_valid_r <= cfg_valid_nxt;
      expect_r    <= expect_nxt;
      rdata_r     <= rdata_nxt;
      err_r       <= err_nxt;
    end
  end

  // One wait-free access phase
  assign PREADY  = 1'b1;
  assign PRDATA  = rdata_r;
  assign PSLVERR = PSEL & PENABLE & err_r;

  // ----------------------------------------------------------------
  // Per-slot comparison and output actions
  // ----------------------------------------------------------------
  logic       allow;
  logic       loss;
  logic [7:0] mism_lo;
  logic [7:0] mism_hi;

  for (genvar s = 0; s < NSLOT; s++)
  begin : g_slot
    // Configured slots only; empty ones are ignored
    assign mism[s] = (expect_r[s*TYPE_W +: TYPE_W] != TYPE_W'(0))
                  && (expect_r[s*TYPE_W +: TYPE_W]
                      != sync_r[s*TYPE_W +: TYPE_W]);
    assign SLOT_UPDATE_EN[s] = allow & ~mism[s];
    assign WORD_ZERO[s] = loss & ~freeze_r & zsel_r[s];
    assign WORD_HOLD[s] = loss & ~WORD_ZERO[s];
  end

  assign BASE_OFFLINE = ~ctrl_r.tolerance & (|mism);
  assign loss  = ~link_s | BASE_OFFLINE;
  assign allow = link_s & cfg_valid_r & ~BASE_OFFLINE;
  assign DISC_CLEAR = loss & ~freeze_r;
  assign DISC_HOLD  = loss & freeze_r;

  // Status display code
  always_comb
  begin
    if (!link_s)
      STATUS_DIGIT = remote_io_pkg::DIGIT_NO_LINK;
    else if (!cfg_valid_r)
      STATUS_DIGIT = remote_io_pkg::DIGIT_NO_CFG;
    else if (|mism)
      STATUS_DIGIT = remote_io_pkg::DIGIT_MISMATCH;
    else
      STATUS_DIGIT = remote_io_pkg::DIGIT_READY;
  end
  assign STATUS_POINT = ctrl_r.tolerance;

  // Diagnostic bytes, index 0 is byte 1, bit 7 is MSB
  assign mism_lo = 8'(mism);
  assign mism_hi = 8'(mism >> 8);
  always_comb
  begin
    diag[0]  = 8'h00;
    diag[0][remote_io_pkg::ST1_EXT_BIT]       = 1'b1;
    diag[0][remote_io_pkg::ST1_CFG_ERR_BIT]   = |mism;
    diag[0][remote_io_pkg::ST1_NOT_READY_BIT] = ~cfg_valid_r;
    diag[1]  = remote_io_pkg::DIAG_ST2_FIXED;
    diag[2]  = 8'h00;
    diag[3]  = remote_io_pkg::DIAG_NO_MASTER;
    diag[4]  = IDENT_HI;
    diag[5]  = IDENT_LO;
    diag[6]  = remote_io_pkg::DIAG_DEV_HDR;
    diag[7]  = 8'h00;
    diag[8]  = 8'h00;
    diag[9]  = 8'h00;
    diag[10] = mism_lo;
    diag[11] = mism_hi;
    diag[12] = remote_io_pkg::DIAG_ID_HDR;
    diag[13] = mism_lo;
    diag[14] = mism_hi;
    diag[15] = 8'h00;                                   // Past byte 15
  end

  // ----------------------------------------------------------------
  // Update scheduler
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_r;
  logic [31:0] tick_cnt_nxt;
  logic [7:0]  ms_cnt_r;
  logic [7:0]  ms_cnt_nxt;
  logic [7:0]  word_cnt_r;
  logic [7:0]  word_cnt_nxt;
  logic        disc_r;
  logic        disc_nxt;
  logic        word_r;
  logic        word_nxt;
  logic [7:0]  ivl;
  logic [7:0]  fac;

  // Zero settings act as one
  assign ivl = (ctrl_r.interval == 8'h00) ? 8'h01 : ctrl_r.interval;
  assign fac = (ctrl_r.factor == 8'h00) ? 8'h01 : ctrl_r.factor;

  // Millisecond tick, interval count and word factor count
  always_comb
  begin
    tick_cnt_nxt = tick_cnt_r + 32'h0000_0001;
    ms_cnt_nxt   = ms_cnt_r;
    word_cnt_nxt = word_cnt_r;
    disc_nxt     = 1'b0;
    word_nxt     = 1'b0;
    if (tick_cnt_r >= 32'(TICK_DIV - 1))
    begin
      tick_cnt_nxt = 32'h0000_0000;
      if (ms_cnt_r + 8'h01 >= ivl)
      begin
        ms_cnt_nxt = 8'h00;
        disc_nxt   = allow | ctrl_r.tolerance & link_s & cfg_valid_r;
        if (disc_nxt)
        begin
          if (word_cnt_r + 8'h01 >= fac)
          begin
            word_cnt_nxt = 8'h00;
            word_nxt     = 1'b1;
          end
          else
            word_cnt_nxt = word_cnt_r + 8'h01;
        end
      end
      else
        ms_cnt_nxt = ms_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      tick_cnt_r <= 32'h0000_0000;
      ms_cnt_r   <= 8'h00;
      word_cnt_r <= 8'h00;
      disc_r     <= 1'b0;
      word_r     <= 1'b0;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_nxt;
      ms_cnt_r   <= ms_cnt_nxt;
      word_cnt_r <= word_cnt_nxt;
      disc_r     <= disc_nxt;
      word_r     <= word_nxt;
    end
  end
  assign DISC_UPDATE = disc_r;
  assign WORD_UPDATE = word_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence s_disc;
    DISC_UPDATE;
  endsequence

  a_disc_spacing: assert property (s_disc |=> !DISC_UPDATE [*7])
    else $error("Discrete updates closer than one tick");
  a_word_with_disc: assert property (WORD_UPDATE |-> DISC_UPDATE)
    else $error("Word update without discrete update");
  a_strict_no_upd: assert property
    (!ctrl_r.tolerance && (|mism) |-> SLOT_UPDATE_EN == '0)
    else $error("Update enabled during strict mismatch");
  a_tol_skip: assert property
    (ctrl_r.tolerance |-> (SLOT_UPDATE_EN & mism) == '0)
    else $error("Mismatched slot still updated");
  a_offline_disc: assert property
    (BASE_OFFLINE && !freeze_r |-> DISC_CLEAR && !DISC_HOLD)
    else $error("Offline base not clearing outputs");
  a_freeze_word: assert property
    (freeze_r && loss |-> WORD_ZERO == '0 && WORD_HOLD == '1)
    else $error("Freeze did not hold word outputs");
  a_point_digit: assert property
    (STATUS_POINT == ctrl_r.tolerance && (!(|mism) || !link_s
     || !cfg_valid_r || STATUS_DIGIT == remote_io_pkg::DIGIT_MISMATCH))
    else $error("Mismatch status display wrong");
  a_strap_stable: assert property
    (strap_done_r |=> $stable(freeze_r))
    else $error("Jumper state changed after startup");
  a_ident_bytes: assert property
    (diag[4] == IDENT_HI && diag[5] == IDENT_LO)
    else $error("Identification bytes wrong");
  a_link_loss: assert property
    ($fell(link_s) |=> !DISC_UPDATE [*3])
    else $error("Update issued after link loss");
endmodule
`default_nettype wire

// ---- bench/backplane_model.sv ----
/*
  Far side of the block: link from the master, backplane modules, and a
  meter of update pulses. Assumes MCLK is shared with the block and the
  bench issues the link, plug and zero-select commands.
*/
`timescale 1ns/1ps
`default_nettype none
module backplane_model (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         link_cmd,
  input  wire logic [127:0] plug_cmd,
  input  wire logic [15:0]  zero_cmd,
  input  wire logic         disc_up,
  input  wire logic         word_up,
  output logic              link_up,
  output logic [127:0]      types,
  output logic [15:0]       zero_sel,
  output logic [15:0]       gap_r,
  output logic [15:0]       ratio_r,
  output logic [15:0]       quiet_r
);
  logic [15:0] since_w_r;
  // --------------------------------------------------------------
  // Pins change just after the edge; pulse spacing is measured
  // --------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    link_up <= link_cmd;
    types <= plug_cmd;
    zero_sel <= zero_cmd;
    if (reset)
    begin
      gap_r <= 16'h0000;
      ratio_r <= 16'h0000;
      quiet_r <= 16'h0000;
      since_w_r <= 16'h0000;
    end
    else if (disc_up)
    begin
      gap_r <= quiet_r;
      quiet_r <= 16'h0001;
      since_w_r <= word_up ? 16'h0000 : since_w_r + 16'h0001;
      if (word_up)
        ratio_r <= since_w_r + 16'h0001;
    end
    else
      quiet_r <= quiet_r + 16'h0001;
  end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
/*
  Self-checking bench of the remote base controller: APB master, scenario
  sequence and a result monitor fed by a queue of expected values.
  Assumes the package and the design module are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int TDIV = 8;
  localparam int IV [3] = '{255, 1, 3};
  localparam int FV [3] = '{1, 255, 3};
  localparam logic [7:0] D0 = remote_io_pkg::OFS_DIAG0;
  logic mclk = 1'b0, reset = 1'b1, look = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, jfit = 1'b0, jfrz = 1'b1, link_cmd = 1'b0;
  logic [127:0] plug = 128'h0, types;
  logic [15:0] zero_cmd = 16'h0, zsel, slot_en, wzero, whold;
  logic [15:0] gap, ratio, quiet, rnd;
  logic link_up, dup, wup, dclr, dhold, offl, point;
  logic [3:0] digit;
  logic [2:0] lsel = 3'h0;
  logic [7:0] t0, t1;
  logic [32:0] exp_q [$];
  int err_total = 0, n_checks = 0;

  always #4 mclk = ~mclk;

  remote_base_ctrl #(.NSLOT(16), .TYPE_W(8), .TICK_DIV(TDIV),
    .IDENT_HI(8'hA5), .IDENT_LO(8'h69)) dut (   // Arbitrary ident values
    .MCLK(mclk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINK_UP(link_up),
    .JUMPER_FITTED(jfit), .JUMPER_FREEZE(jfrz), .INSTALLED_TYPE(types),
    .MODULE_ZERO_SEL(zsel), .DISC_UPDATE(dup), .WORD_UPDATE(wup),
    .SLOT_UPDATE_EN(slot_en), .DISC_CLEAR(dclr), .DISC_HOLD(dhold),
    .WORD_ZERO(wzero), .WORD_HOLD(whold), .BASE_OFFLINE(offl),
    .STATUS_DIGIT(digit), .STATUS_POINT(point));

  backplane_model far (.mclk(mclk), .reset(reset), .link_cmd(link_cmd),
    .plug_cmd(plug), .zero_cmd(zero_cmd), .disc_up(dup), .word_up(wup),
    .link_up(link_up), .types(types), .zero_sel(zsel), .gap_r(gap),
    .ratio_r(ratio), .quiet_r(quiet));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [32:0] port_val(input logic [2:0] s);
    case (s)
      3'h0: return {28'h0, point, digit};
      3'h1: return {30'h0, offl, dclr, dhold};
      3'h2: return {31'h0, slot_en[1:0]};
      3'h3: return {1'b0, whold, wzero};
      3'h4: return {17'h0, gap};
      3'h5: return {17'h0, ratio};
      default: return {32'h0, quiet > 16'h0040};
    endcase
  endfunction

  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    n_checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wait_c(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // APB transfer; a read notes its expected {PSLVERR, PRDATA}
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    if (!w)
      exp_q.push_back(e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (!pready) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask

  // Note an expected port view and ask the monitor to look
  task automatic see(input logic [2:0] s, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    look <= 1'b1;
    lsel <= s;
    @(posedge mclk);
    look <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge mclk);
    reset <= 1'b1;
    wait_c(16);
    reset <= 1'b0;
    wait_c(4);
  endtask

  task automatic done(input string n);
    $display("test %s done", n);
  endtask

  // Monitor: compares results with the oldest note
  always @(posedge mclk)
  begin
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, exp_q.pop_front());
    if (look)
      chk(port_val(lsel), exp_q.pop_front());
  end

  // Hang guard
  initial
  begin
    wait_c(40000);
    err_total++;
    final_report();
  end

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial
  begin
    rnd = 16'hD153;
    do_reset();
    rd(remote_io_pkg::OFS_CTRL, 33'h000000201);
    rd(remote_io_pkg::OFS_CFG, 33'h0);
    rd(8'h08, {1'b1, 32'h0});
    see(3'h0, 33'h03);
    see(3'h1, 33'h2);
    done("reset");
    rnd = lfsr(rnd);
    t0 = {1'b0, rnd[6:0]} | 8'h01;
    rnd = lfsr(rnd);
    t1 = {1'b0, rnd[14:8]} | 8'h01;
    plug[15:0] <= {t1, t0};
    wr(remote_io_pkg::OFS_EXPECT0, {16'h0, t1, t0});
    wr(remote_io_pkg::OFS_CFG, 32'h1);
    link_cmd <= 1'b1;
    wait_c(40);
    see(3'h0, 33'h0);
    see(3'h1, 33'h0);
    rd(remote_io_pkg::OFS_EXPECT0, {17'h0, t1, t0});
    rd(D0 + 8'h04, 33'h0000669A5);
    rd(D0 + 8'h0C, 33'h000000043);
    done("config");
    for (int i = 0; i < 3; i++)
    begin
      wr(remote_io_pkg::OFS_CTRL, {16'h0, 8'(FV[i]), 8'(IV[i])});
      wait_c((2 * FV[i] + 2) * IV[i] * TDIV + 40);
      see(3'h4, 33'(IV[i] * TDIV));
      see(3'h5, 33'(FV[i]));
    end
    done("rate");
    wr(remote_io_pkg::OFS_CTRL, 32'h201);
    plug[15:8] <= 8'h00;
    wait_c(60);
    see(3'h0, 33'h02);
    see(3'h1, 33'h6);
    wait_c(80);
    see(3'h6, 33'h1);
    rd(D0 + 8'h08, 33'h000020000);
    rd(D0 + 8'h0C, 33'h000000243);
    rd(remote_io_pkg::OFS_MISMATCH, 33'h000020002);
    plug[15:8] <= t1 | 8'h80;
    wait_c(20);
    see(3'h0, 33'h02);
    plug[23:8] <= {8'h33, t1};
    wait_c(80);
    see(3'h0, 33'h0);
    see(3'h6, 33'h0);
    done("strict");
    wr(remote_io_pkg::OFS_CTRL, 32'h10201);
    wait_c(10);
    see(3'h0, 33'h10);
    plug[15:8] <= 8'h00;
    wait_c(80);
    see(3'h0, 33'h12);
    see(3'h1, 33'h0);
    see(3'h2, 33'h1);
    see(3'h6, 33'h0);
    done("tolerant");
    rnd = lfsr(rnd);
    zero_cmd <= rnd;
    link_cmd <= 1'b0;
    wait_c(10);
    see(3'h0, 33'h13);
    see(3'h1, 33'h2);
    see(3'h3, {1'b0, ~rnd, rnd});
    done("loss off");
    jfit <= 1'b1;
    jfrz <= 1'b1;
    do_reset();
    jfrz <= 1'b0;
    wait_c(10);
    see(3'h1, 33'h1);
    see(3'h3, {1'b0, 16'hFFFF, 16'h0});
    rd(remote_io_pkg::OFS_STATUS, 33'h23);
    done("freeze");
    final_report();
  end
endmodule
`default_nettype wire
